// ---- rtl/tuhc_top.sv ----
// tuhc_top: upper timer half with wishbone registers and output pin
//
// Behaviour
// - upper fields act only in unchained dual mode, except the invert bit
// - reserved control bits read zero, ignore writes
// - enable code 00b holds the count
// - code 01b counts once, stops at period
// - code 10b wraps to zero after period
// - pulse width is field plus one cycles
// - pulse width ignored in clock mode
// - watchdog mode forces pulse output mode
// - pulse mode emits pulse at each period match
// - clock mode toggles output at period match
// - invert bit inverts generated output
// - read-only status bit shows output level
// - output can be routed to the pin
// - own 32-bit period compared against counter
// - hardware reset clears counter, soft reset holds
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module tuhc_top #(
   parameter int unsigned CNT_W = 32
) (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire tuhc_pkg::tuhc_wb_req_type wb_req,
   output tuhc_pkg::tuhc_wb_rsp_type     wb_rsp,
   input  wire logic                     timer_clk_pin,
   output logic                          timer_out_pin
);
   import tuhc_pkg::*;

   // counter must fit the data bus and be wide enough to count
   if (CNT_W < 2 || CNT_W > DATA_W) begin : g_chk
      $error("tuhc_top: CNT_W must lie between 2 and DATA_W");
   end

   // register state
   // all software-visible state is held in flops here
   // each _next value is formed by the decode below
   // control keeps only its writable bits; status is
   //   merged in on the read path, never stored
   // counter and period are CNT_W wide; narrower builds
   //   read back zero in the unused upper bits
   // output level kept twice: status copy for reads,
   //   pin copy gated by the route bit
   logic [31:0]      ctl_reg;          // timer_control writable bits
   logic [31:0]      ctl_next;
   logic [31:0]      gbl_reg;          // global_control
   logic [31:0]      gbl_next;
   logic [CNT_W-1:0] cnt_reg;          // upper_counter
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] prd_reg;          // upper_period
   logic [CNT_W-1:0] prd_next;
   logic             done_reg;         // one-shot finished
   logic             done_next;
   logic             ack_reg;          // bus acknowledge
   logic             ack_next;
   logic [31:0]      rdat_reg;         // captured read data
   logic [31:0]      rdat_next;
   logic             pin_reg;          // output pin level
   logic             pin_next;
   logic             stat_reg;         // final output level
   logic             stat_next;

   // bus decode
   // classic single cycle: a request is taken once, on the
   //   edge where cyc and stb are high and ack is still low
   // ack is registered, so it rises one cycle after taking
   // the ack term blocks a second take of a held request;
   //   a master holding stb gets one access every other cycle
   // byte address bits 1:0 are ignored, words are aligned
   // unmapped words still ack, so a stray access never
   //   hangs the bus
   wire        bus_req  = wb_req.cyc & wb_req.stb;          // active cycle
   wire        bus_take = bus_req & ~ack_reg;               // one per access
   wire        bus_wr   = bus_take & wb_req.we;             // write strobe
   wire [ADDR_W-1:0] word_adr = {wb_req.adr[ADDR_W-1:2], 2'b00};
   wire        hit_ctl  = (word_adr == OFF_CONTROL);        // decode
   wire        hit_cnt  = (word_adr == OFF_COUNTER);
   wire        hit_prd  = (word_adr == OFF_PERIOD);
   wire        hit_gbl  = (word_adr == OFF_GLOBAL);
   wire        wr_ctl   = bus_wr & hit_ctl;
   wire        wr_cnt   = bus_wr & hit_cnt;
   wire        wr_prd   = bus_wr & hit_prd;
   wire        wr_gbl   = bus_wr & hit_gbl;

   // byte enables widened to a bit mask
   logic [31:0] lane_mask;
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign lane_mask[8*i +: 8] = {8{wb_req.sel[i]}};
   end

   // merged write data for each register
   wire [31:0] ctl_wmask = CTL_WR_MASK & lane_mask;
   wire [31:0] gbl_wmask = GBL_WR_MASK & lane_mask;
   wire [31:0] ctl_wval  = (ctl_reg & ~ctl_wmask)
                         | (wb_req.dat & ctl_wmask);
   wire [31:0] gbl_wval  = (gbl_reg & ~gbl_wmask)
                         | (wb_req.dat & gbl_wmask);
   wire [CNT_W-1:0] cnt_wval = (cnt_reg & ~lane_mask[CNT_W-1:0])
                             | (wb_req.dat[CNT_W-1:0]
                                & lane_mask[CNT_W-1:0]);
   wire [CNT_W-1:0] prd_wval = (prd_reg & ~lane_mask[CNT_W-1:0])
                             | (wb_req.dat[CNT_W-1:0]
                                & lane_mask[CNT_W-1:0]);

   // field extraction
   // control fields are read from the stored word, so a
   //   change takes effect on the clock after the write
   // global timer mode, soft reset and route sit in
   //   global_control; their layout is local to this block
   // soft reset is active low: 0 holds the count and forces the raw output level low
   // fields are plain wires, no extra pipeline stage
   // enable codes 00 and 11 are both treated as stopped
   // the select bit is gated by the global mode below
   wire [1:0] ena_mode = ctl_reg[CTL_ENA_LSB +: 2];       // enable mode
   wire [1:0] pwid     = ctl_reg[CTL_PWID_LSB +: 2];      // pulse width
   wire       cp_bit   = ctl_reg[CTL_CP_BIT];             // clock select
   wire       inv_bit  = ctl_reg[CTL_INV_BIT];            // output invert
   wire [1:0] tmode    = gbl_reg[GBL_MODE_LSB +: 2];      // timer mode
   wire       srst_n   = gbl_reg[GBL_SRST_BIT];           // soft reset
   wire       route_en = gbl_reg[GBL_ROUTE_BIT];          // pin route

   // upper fields only steer the timer in unchained dual mode
   wire mode_active = (tmode == TMODE_UNCHAINED);
   // watchdog forces pulse mode whatever the select bit says
   wire clock_mode  = cp_bit & (tmode != TMODE_WATCHDOG);

   // timer clock from the pin
   // the pin is asynchronous to clk; two flops settle it
   //   before any logic reads it
   // one tick per rising edge, one clk cycle long
   // the pin must stay high and low for at least two clk
   //   cycles each, or edges are lost
   // latency from pin edge to tick is two clk cycles
   // ticks are dropped outside unchained mode and while
   //   the soft reset bit is low
   logic tclk_rise;                    // one clk per timer clock edge

   tuhc_sync u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (timer_clk_pin),
      .rise     (tclk_rise)
   );

   // ticks reach the timer only while it is active and out of reset
   wire tick = tclk_rise & mode_active & srst_n;

   // counting
   // the counter steps on ticks only, never on plain clk
   // a match is counter equal to period, seen on a tick
   // continuous: the tick that finds the match loads zero,
   //   so one full timer cycle lasts the period value plus one ticks
   // one-shot: the match tick holds the count and sets the
   //   done flag; leaving code 01 or a counter write rearms
   // a software counter write wins over counting
   // a period below the count is only met after wrap
   // only the once and continuous codes count
   wire ena_once = (ena_mode == ENA_ONCE);
   wire ena_cont = (ena_mode == ENA_CONT);
   // off and the spare code both hold the value
   wire run      = (ena_once & ~done_reg) | ena_cont;
   wire at_prd   = (cnt_reg == prd_reg);
   wire step     = tick & run;                            // counting tick
   wire prd_hit  = step & at_prd;                         // period match

   // next counter value
   always_comb begin
      cnt_next = cnt_reg;
      if (wr_cnt) begin
         cnt_next = cnt_wval;                     // software load wins
      end else if (prd_hit && ena_cont) begin
         cnt_next = '0;
      end else if (prd_hit) begin
         cnt_next = cnt_reg;
      end else if (step) begin
         cnt_next = cnt_reg + 1'b1;               // count up
      end
   end

   // one-shot finished flag; setting wins over clearing
   wire done_set = prd_hit & ena_once;
   wire done_clr = ~ena_once | wr_cnt;                    // rearm
   assign done_next = done_set | (done_reg & ~done_clr);

   // output waveform
   // pulse or clock level is built in the generator from
   //   the match and the tick stream
   // pulse mode: high for pulse-width field plus one ticks
   // clock mode: toggles per match, width field unused
   // soft reset forces the raw level low before invert
   // invert applies after the generator, so the idle level
   //   of an inverted output is high
   // hazard: a match during a pulse restarts the width
   logic raw_level;                    // generated output before invert

   tuhc_out_gen #(
      .PWID_W (2)
   ) u_out (
      .clk        (clk),
      .rst_b      (rst_b),
      .clear      (~srst_n),
      .tick       (tick),
      .hit        (prd_hit),
      .clock_mode (clock_mode),
      .pwid       (pwid),
      .level      (raw_level)
   );

   // invert, then optionally drive the pin
   assign stat_next = raw_level ^ inv_bit;
   assign pin_next  = route_en & stat_next;

   // register writes
   // write merge masks with byte enables and writable bits
   // reserved control bits can never be set
   // status bit 16 is outside the write mask, read-only
   // the period takes effect on the next tick compare
   // a write to an unmapped word changes nothing
   // global_control writes apply on the same edge as
   //   control writes, no ordering between registers
   // counter writes are handled in the counting logic
   assign ctl_next = wr_ctl ? ctl_wval : ctl_reg;
   assign gbl_next = wr_gbl ? gbl_wval : gbl_reg;
   assign prd_next = wr_prd ? prd_wval : prd_reg;

   // read data and acknowledge
   // read data is registered and shown only with ack;
   //   between accesses the data bus reads zero
   // the word is sampled from the state at the taking edge
   // status comes from the registered output level, so a
   //   read sees the level one clk old
   // counter and period are zero-extended to the bus
   // an unmapped read returns zero
   // writes return the addressed word as well
   wire [31:0] ctl_rd = ctl_reg
                      | ({31'h0, stat_reg} << CTL_STAT_BIT);
   wire [31:0] cnt_rd = DATA_W'(cnt_reg);
   wire [31:0] prd_rd = DATA_W'(prd_reg);
   // unmapped words read as zero
   wire [31:0] rd_mux = hit_ctl ? ctl_rd
                      : hit_cnt ? cnt_rd
                      : hit_prd ? prd_rd
                      : hit_gbl ? gbl_reg
                      : 32'h00000000;

   assign ack_next  = bus_take;                           // one cycle
   assign rdat_next = bus_take ? rd_mux : 32'h00000000;

   // control and bus registers
   // synchronous reset, active low, clears every field
   // after reset the soft reset bit is low, so the timer
   //   stays held until software sets it
   // mode 00 after reset: upper fields other than the invert bit have no effect
   // the period resets to zero
   // ack and data reset low so the bus is idle
   // counter flops are kept apart below, because only
   //   the hardware reset may clear the count
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctl_reg  <= CTL_RESET;
         gbl_reg  <= GBL_RESET;
         prd_reg  <= '0;
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         ctl_reg  <= ctl_next;
         gbl_reg  <= gbl_next;
         prd_reg  <= prd_next;
         ack_reg  <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   // counter state; only the hardware reset clears the count
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   // output level registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_reg <= 1'b0;
         pin_reg  <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         pin_reg  <= pin_next;
      end
   end

   // ports straight from flip-flops
   assign wb_rsp.ack    = ack_reg;
   assign wb_rsp.dat    = rdat_reg;
   assign timer_out_pin = pin_reg;

endmodule : tuhc_top

// ---- shared/tuhc_pkg.sv ----
// tuhc_pkg: constants, field layout and carrier types of the upper timer
package tuhc_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 4;                 // byte address bits
   localparam int unsigned DATA_W = 32;                // data bus width

   // register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;   // timer_control
   localparam logic [ADDR_W-1:0] OFF_COUNTER = 4'h4;   // upper_counter
   localparam logic [ADDR_W-1:0] OFF_PERIOD  = 4'h8;   // upper_period
   localparam logic [ADDR_W-1:0] OFF_GLOBAL  = 4'hc;   // global_control

   // timer_control field positions
   localparam int unsigned CTL_ENA_LSB  = 22;          // upper_enable_mode
   localparam int unsigned CTL_PWID_LSB = 20;          // upper_pulse_width
   localparam int unsigned CTL_CP_BIT   = 19;          // upper_clock_or_pulse
   localparam int unsigned CTL_INV_BIT  = 17;          // upper_output_invert
   localparam int unsigned CTL_STAT_BIT = 16;          // upper_output_status

   // timer_control writable bits and reset value
   localparam logic [31:0] CTL_WR_MASK = 32'h00fa0000;
   localparam logic [31:0] CTL_RESET   = 32'h00000000;

   // global_control field positions
   localparam int unsigned GBL_MODE_LSB  = 2;          // global_timer_mode
   localparam int unsigned GBL_SRST_BIT  = 1;          // upper_soft_reset_n
   localparam int unsigned GBL_ROUTE_BIT = 0;          // pin route enable
   localparam logic [31:0] GBL_WR_MASK   = 32'h0000000f;
   localparam logic [31:0] GBL_RESET     = 32'h00000000;

   // global_timer_mode codes
   localparam logic [1:0] TMODE_64BIT     = 2'h0;
   localparam logic [1:0] TMODE_UNCHAINED = 2'h1;
   localparam logic [1:0] TMODE_WATCHDOG  = 2'h2;
   localparam logic [1:0] TMODE_CHAINED   = 2'h3;

   // upper_enable_mode codes
   localparam logic [1:0] ENA_OFF  = 2'h0;
   localparam logic [1:0] ENA_ONCE = 2'h1;
   localparam logic [1:0] ENA_CONT = 2'h2;
   localparam logic [1:0] ENA_RSVD = 2'h3;

   // wishbone request from the master
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADDR_W-1:0] adr;
      logic [3:0]        sel;
      logic [DATA_W-1:0] dat;
   } tuhc_wb_req_type;

   // wishbone answer to the master
   typedef struct packed {
      logic              ack;
      logic [DATA_W-1:0] dat;
   } tuhc_wb_rsp_type;

endpackage : tuhc_pkg

// ---- rtl/tuhc_sync.sv ----
// tuhc_sync: two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module tuhc_sync (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic async_in,
   output logic      rise
);
   import tuhc_pkg::*;

   logic meta_reg;                 // first stage, read only by second
   logic sync_reg;                 // second stage, safe level
   logic last_reg;                 // previous safe level

   // synchroniser chain and edge history
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // rising edge of the safe level
   assign rise = sync_reg & ~last_reg;

endmodule : tuhc_sync

// ---- rtl/tuhc_out_gen.sv ----
// tuhc_out_gen: pulse or clock waveform for the upper timer output
`timescale 1ns/1ns
module tuhc_out_gen #(
   parameter int unsigned PWID_W = 2
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              clear,
   input  wire logic              tick,
   input  wire logic              hit,
   input  wire logic              clock_mode,
   input  wire logic [PWID_W-1:0] pwid,
   output logic                   level
);
   import tuhc_pkg::*;

   // width field must be at least one bit
   if (PWID_W < 1) begin : g_chk
      $error("tuhc_out_gen: PWID_W must be at least 1");
   end

   logic              level_reg;   // raw output level
   logic              level_next;
   logic [PWID_W-1:0] left_reg;    // pulse ticks remaining after this one
   logic [PWID_W-1:0] left_next;

   wire pulse_end = tick & level_reg & (left_reg == '0);   // last tick done

   // next level: toggle, start, end or hold
   always_comb begin
      level_next = level_reg;
      left_next  = left_reg;
      if (clear) begin
         level_next = 1'b0;
         left_next  = '0;
      end else if (hit && clock_mode) begin
         level_next = ~level_reg;
      end else if (hit) begin
         level_next = 1'b1;
         left_next  = pwid;
      end else if (!clock_mode && pulse_end) begin
         level_next = 1'b0;
      end else if (!clock_mode && tick && level_reg) begin
         left_next  = left_reg - 1'b1;
      end
   end

   // output state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         level_reg <= 1'b0;
         left_reg  <= '0;
      end else begin
         level_reg <= level_next;
         left_reg  <= left_next;
      end
   end

   assign level = level_reg;

endmodule : tuhc_out_gen

// ---- dv/tuhc_top_properties.sv ----
// tuhc_top_properties: port-level assertions for the upper timer half
`timescale 1ns/1ns
module tuhc_top_properties #(
   parameter int unsigned CNT_W = 32
) (
   input wire logic                      clk,
   input wire logic                      rst_b,
   input wire tuhc_pkg::tuhc_wb_req_type wb_req,
   input wire tuhc_pkg::tuhc_wb_rsp_type wb_rsp,
   input wire logic                      timer_clk_pin,
   input wire logic                      timer_out_pin
);
   import tuhc_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // decoded bus events
   wire        take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   wire        ctl_rd = wb_rsp.ack && !wb_req.we && wb_req.adr[3:2] == 2'h0;
   logic       pin_q;      // last timer pin level
   logic [3:0] quiet_reg;  // cycles since pin change or bus answer
   logic [3:0] quiet_next; // next quiet count, saturating
   assign quiet_next = (timer_clk_pin != pin_q || wb_rsp.ack) ? 4'h0 :
                       (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;

   // quiet counter, cleared by reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         quiet_reg <= 4'h0;
         pin_q     <= 1'b0;
      end else begin
         quiet_reg <= quiet_next;
         pin_q     <= timer_clk_pin;
      end
   end

   a_ack_answer: assert property (take |=> wb_rsp.ack ##1 !wb_rsp.ack)
      else $error("bus request not answered in one cycle");
   a_ack_cause: assert property (wb_rsp.ack |-> $past(take))
      else $error("ack without a request");
   a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
      else $error("read data not zero outside ack");
   a_ctl_rsvd: assert property (ctl_rd |->
      (wb_rsp.dat & 32'hff04ffff) == 32'h0)
      else $error("reserved control bits read nonzero");
   a_status_pin: assert property (ctl_rd && $past(timer_out_pin) |->
      wb_rsp.dat[CTL_STAT_BIT])
      else $error("status bit low while pin high");
   a_pin_quiet: assert property (quiet_reg >= 4'ha |->
      $stable(timer_out_pin))
      else $error("output moved without tick or write");
   a_reset_clear: assert property ($rose(rst_b) |->
      !wb_rsp.ack && !timer_out_pin && wb_rsp.dat == 32'h0)
      else $error("outputs not cleared by reset");

   c_write: cover property (wb_rsp.ack && wb_req.we);
   c_ctl_read: cover property (ctl_rd && wb_rsp.dat[CTL_STAT_BIT]);
   c_pin_rise: cover property ($rose(timer_out_pin));
endmodule : tuhc_top_properties

bind tuhc_top tuhc_top_properties #(.CNT_W(CNT_W)) i_tuhc_top_properties (
   .clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .timer_clk_pin(timer_clk_pin), .timer_out_pin(timer_out_pin));

// ---- dv/tb_tuhc_top.sv ----
// tb_tuhc_top: register-level tests of the upper timer half
`timescale 1ns/1ns
module tb_tuhc_top;
   import tuhc_pkg::*;
   logic            clk;            // 50 MHz system clock
   logic            rst_b;          // synchronous reset, active low
   tuhc_wb_req_type wb_req;         // bus request
   tuhc_wb_rsp_type wb_rsp;         // bus answer
   logic            timer_clk_pin;  // timer input clock
   logic            timer_out_pin;  // timer output
   int              bad_count;      // mismatches
   int              checks;         // comparisons
   // global and control pairs under which the count must hold
   logic [31:0] hold_glb [6] = '{32'h7, 32'h7, 32'h3, 32'hb, 32'hf, 32'h5};
   logic [31:0] hold_ctl [6] = '{32'h0, 32'h00c00000, 32'h00800000,
                                 32'h00800000, 32'h00800000, 32'h00800000};

   tuhc_top #(.CNT_W(32)) i_tuhc_top (
      .clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .timer_clk_pin(timer_clk_pin), .timer_out_pin(timer_out_pin));

   // clock generation, 20 ns period
   always #10 clk = ~clk;

   // compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // one classic cycle, held until ack is sampled
   task automatic wb_cycle(input logic we, input logic [3:0] adr,
                           input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:wd};
      @(posedge clk);
      while (wb_rsp.ack !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk);
      if (n >= 50) begin
         bad_count++;
         $display("ERROR at %0t: no ack", $time);
         stop_test();
      end
   endtask : wb_cycle

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb_cycle(1'b1, a, d, x);
   endtask : wr

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] x;
      wb_cycle(1'b0, a, 32'h0, x);
      check(x, e);
   endtask : rd_chk

   // one timer clock, four system clocks high and low
   task automatic tick();
      timer_clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      timer_clk_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : tick

   // control word from fields
   function automatic logic [31:0] mk(input logic [1:0] e, input logic [1:0] w,
                                      input logic c, input logic v);
      return {8'h0, e, w, c, 1'b0, v, 17'h0};
   endfunction : mk

   // twelve ticks from a period match, counting high output samples
   task automatic run(input logic [31:0] ctl, output int hi);
      wr(OFF_GLOBAL, 32'h5);    // soft reset clears the output
      wr(OFF_COUNTER, 32'h5);   // start at period, first tick matches
      wr(OFF_CONTROL, ctl);
      wr(OFF_GLOBAL, 32'h7);    // unchained, running, routed to pin
      hi = 0;
      repeat (12) begin
         tick();
         hi += (timer_out_pin === 1'b1) ? 1 : 0;
      end
   endtask : run

   // verdict and end of run
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // watchdog, well above the expected 1000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      stop_test();
   end

   // main sequence
   initial begin
      int h;
      clk = 1'b0;
      rst_b = 1'b0;
      wb_req = '0;
      timer_clk_pin = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd_chk(OFF_CONTROL, 32'h0);
      rd_chk(OFF_COUNTER, 32'h0);
      rd_chk(OFF_PERIOD, 32'h0);
      rd_chk(OFF_GLOBAL, 32'h0);
      $display("reset values done");
      // reserved bits, inverted idle output on status, pin not routed
      wr(OFF_CONTROL, 32'hffffffff);
      rd_chk(OFF_CONTROL, 32'h00fb0000);
      check({31'h0, timer_out_pin}, 32'h0);
      $display("control access done");
      wr(OFF_PERIOD, 32'h5);
      for (int p = 0; p < 4; p++) begin
         run(mk(ENA_CONT, p[1:0], 1'b0, 1'b0), h);
         check(32'(h), 32'(2 * (p + 1)));
      end
      run(mk(ENA_CONT, 2'h3, 1'b1, 1'b0), h);
      check(32'(h), 32'h6);
      run(mk(ENA_CONT, 2'h0, 1'b0, 1'b1), h);
      check(32'(h), 32'ha);
      rd_chk(OFF_CONTROL, 32'h00830000);
      rd_chk(OFF_COUNTER, 32'h5);
      $display("output modes done");
      // one-shot from zero stops at period
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_COUNTER, 32'h0);
      wr(OFF_CONTROL, mk(ENA_ONCE, 2'h0, 1'b0, 1'b0));
      repeat (8) tick();
      rd_chk(OFF_COUNTER, 32'h5);
      $display("one-shot done");
      // count held by disable codes, other global modes, soft reset
      foreach (hold_glb[i]) begin
         wr(OFF_GLOBAL, hold_glb[i]);
         wr(OFF_CONTROL, hold_ctl[i]);
         wr(OFF_COUNTER, 32'h2);
         repeat (3) tick();
         rd_chk(OFF_COUNTER, 32'h2);
      end
      $display("hold cases done");
      repeat (16) @(posedge clk);
      stop_test();
   end
endmodule : tb_tuhc_top
